// File: rtl/rbd_line_buf.sv
// One raw line of delay for the window rows, as a circular memory
`timescale 1ns/100ps
`default_nettype none

module rbd_line_buf #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 1920
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic en,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [$clog2(DEPTH)-1:0] ptr_reg;
   logic ptr_wrap;

   // ----------------------------------------------------------------------
   // Read before write: the word leaving is exactly DEPTH pixels old
   // ----------------------------------------------------------------------
   assign ptr_wrap = (ptr_reg == ($clog2(DEPTH))'(DEPTH - 1));
   assign dout = mem[ptr_reg];

   // Memory has no reset; stale content only reaches border pixels
   always_ff @(posedge clk) begin
      if (en) begin
         mem[ptr_reg] <= din;
      end
   end

   // Pointer walks one step per accepted pixel
   always_ff @(posedge clk) begin
      if (reset) begin
         ptr_reg <= '0;
      end else if (en) begin
         ptr_reg <= ptr_wrap ? '0 : ptr_reg + 1'b1;
      end
   end

endmodule : rbd_line_buf

`default_nettype wire

// File: rtl/rbd_pkg.sv
// Package: register map, field layout, reset values and widths of the raw front end
package rbd_pkg;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BLACK_LEVEL_OFS = 8'h04;
   localparam logic [7:0] ANALOG_GAIN_OFS = 8'h08;
   localparam logic [7:0] SENSOR_DGAIN_OFS = 8'h0C;
   localparam logic [7:0] PIPE_DGAIN_OFS = 8'h10;
   localparam logic [7:0] DYN_THRESH_OFS = 8'h14;
   localparam logic [7:0] DARK_LEVEL_OFS = 8'h18;
   localparam logic [7:0] STATUS_OFS = 8'h1C;

   // ----------------------------------------------------------------------
   // Control field positions and reset values
   // ----------------------------------------------------------------------
   localparam int STATIC_EN_BIT = 0;
   localparam int DYNAMIC_EN_BIT = 1;
   localparam int CLUSTER_LSB = 4;
   localparam int MANUAL_OP_BIT = 6;
   localparam logic STATIC_EN_RST = 1'b0;
   localparam logic DYNAMIC_EN_RST = 1'b0;
   localparam logic [1:0] CLUSTER_RST = 2'h2;
   localparam logic MANUAL_OP_RST = 1'b0;

   // ----------------------------------------------------------------------
   // Gain encoding: 1024 is unity, so the fraction has ten bits
   // ----------------------------------------------------------------------
   localparam int GAIN_W = 16;
   localparam int GAIN_FRAC = 10;
   localparam logic [15:0] GAIN_UNITY = 16'h0400;

   // ----------------------------------------------------------------------
   // Reset values of the pixel thresholds
   // ----------------------------------------------------------------------
   localparam logic [15:0] BLACK_LEVEL_RST = 16'h0000;
   localparam logic [15:0] DYN_THRESH_RST = 16'h0100;
   localparam logic [15:0] DARK_LEVEL_RST = 16'h0010;

   // ----------------------------------------------------------------------
   // Window geometry and position counters
   // ----------------------------------------------------------------------
   localparam int WIN = 5;
   localparam int NBR = 8;
   localparam int POS_W = 16;
   localparam logic [15:0] BORDER = 16'h0004;

endpackage : rbd_pkg

// File: rtl/rbd_top.sv
// Raw black level subtraction, gain and same-colour defect pixel correction with APB
//
// Overview of operation
// [RULE_01] Black level offset is subtracted from every raw pixel, clamped at zero.
// [RULE_02] All gain registers use 1024 as unity gain.
// [RULE_03] Defect correction runs on raw data, before any interpolation or filtering.
// [RULE_04] A 5x5 window is used, comparing only same Bayer colour pixels.
// [RULE_05] An isolated defect among good same-colour neighbours is found and replaced.
// [RULE_06] Clusters of up to three same-colour defects are still corrected.
// [RULE_07] Clusters larger than three need not be corrected.
// [RULE_08] Other colour channels never affect a pixel's decision or replacement.
// [RULE_09] A pixel near zero among bright same-colour neighbours is a dark defect.
// [RULE_10] A pixel clearly brighter than its same-colour neighbours is a dynamic defect.
// [RULE_11] Static correction enable bit, 1 on, 0 off, resets to 0.
// [RULE_12] Dynamic correction enable bit, 1 on, 0 off, resets to 0.
// [RULE_13] Two-bit cluster area bound, 0 to 3, resets to 2.
// [RULE_14] Defects take an estimate from good same-colour neighbours; others pass unchanged.
// [RULE_15] Lines are buffered for the window; output order and timing follow input.
`timescale 1ns/100ps
`default_nettype none

module rbd_top #(
   parameter int PIX_W = 12,
   parameter int LINE_W = 1920
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_valid,
   input wire logic [PIX_W-1:0] in_pixel,
   input wire logic in_sof,
   input wire logic in_eol,
   output logic out_valid,
   output logic [PIX_W-1:0] out_pixel,
   output logic out_sof,
   output logic out_eol
);

   localparam int E_W = PIX_W + 2;
   localparam int PROD_W = PIX_W + rbd_pkg::GAIN_W;
   localparam logic [PIX_W-1:0] PIX_MAX = {PIX_W{1'b1}};

   // ----------------------------------------------------------------------
   // Helpers shared by the datapath
   // ----------------------------------------------------------------------
   // Value ranked k-th largest among the eight neighbours, ties by index
   function automatic logic [PIX_W-1:0] rank_pick(input logic [PIX_W-1:0] n [0:7],
                                                 input logic [2:0] k);
      logic [PIX_W-1:0] pick;
      logic [3:0] above;
      pick = '0;
      for (int i = 0; i < rbd_pkg::NBR; i++) begin
         above = '0;
         for (int j = 0; j < rbd_pkg::NBR; j++) begin
            if ((n[j] > n[i]) || ((n[j] == n[i]) && (j < i))) begin
               above = above + 1'b1;
            end
         end
         if (above == {1'b0, k}) begin
            pick = n[i];
         end
      end
      return pick;
   endfunction : rank_pick

   // Saturating add of a pixel and a threshold
   function automatic logic [PIX_W:0] wide_add(input logic [PIX_W-1:0] a,
                                              input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, b} + 17'(a);
      return (s > 17'(PIX_MAX)) ? {1'b1, PIX_MAX} : (PIX_W+1)'(s);
   endfunction : wide_add

   // ----------------------------------------------------------------------
   // APB register file
   // ----------------------------------------------------------------------
   logic static_en_reg;
   logic dynamic_en_reg;
   logic [1:0] cluster_bound_reg;
   logic manual_op_reg;
   logic [15:0] black_level_reg;
   logic [15:0] analog_gain_reg;
   logic [15:0] sensor_gain_reg;
   logic [15:0] pipe_gain_reg;
   logic [15:0] dyn_thresh_reg;
   logic [15:0] dark_level_reg;
   logic [15:0] fix_count_reg;
   logic [15:0] fix_count_next;
   logic apb_wr;
   logic apb_hit;
   logic [31:0] rd_mux;

   // Slave answers in the first access cycle; unmapped offsets take an error
   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite;
   assign apb_hit = (paddr[1:0] == 2'b00) && (paddr <= rbd_pkg::STATUS_OFS);
   assign pslverr = psel && penable && !apb_hit;

   // Read selection; unused high bits read as zero
   assign rd_mux =
      (paddr == rbd_pkg::CTRL_OFS) ? {25'h000_0000, manual_op_reg, cluster_bound_reg,
                                      2'b00, dynamic_en_reg, static_en_reg} :
      (paddr == rbd_pkg::BLACK_LEVEL_OFS) ? {16'h0000, black_level_reg} :
      (paddr == rbd_pkg::ANALOG_GAIN_OFS) ? {16'h0000, analog_gain_reg} :
      (paddr == rbd_pkg::SENSOR_DGAIN_OFS) ? {16'h0000, sensor_gain_reg} :
      (paddr == rbd_pkg::PIPE_DGAIN_OFS) ? {16'h0000, pipe_gain_reg} :
      (paddr == rbd_pkg::DYN_THRESH_OFS) ? {16'h0000, dyn_thresh_reg} :
      (paddr == rbd_pkg::DARK_LEVEL_OFS) ? {16'h0000, dark_level_reg} :
      (paddr == rbd_pkg::STATUS_OFS) ? {16'h0000, fix_count_reg} : 32'h0000_0000;

   // Read data is captured so that it stands in a flip-flop at the sampling edge
   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Writable registers; the analog and sensor gains are kept for software only
   always_ff @(posedge clk) begin
      if (reset) begin
         static_en_reg <= rbd_pkg::STATIC_EN_RST;  // RULE_11
         dynamic_en_reg <= rbd_pkg::DYNAMIC_EN_RST;  // RULE_12
         cluster_bound_reg <= rbd_pkg::CLUSTER_RST;  // RULE_13
         manual_op_reg <= rbd_pkg::MANUAL_OP_RST;
         black_level_reg <= rbd_pkg::BLACK_LEVEL_RST;
         analog_gain_reg <= rbd_pkg::GAIN_UNITY;  // RULE_02
         sensor_gain_reg <= rbd_pkg::GAIN_UNITY;
         pipe_gain_reg <= rbd_pkg::GAIN_UNITY;
         dyn_thresh_reg <= rbd_pkg::DYN_THRESH_RST;
         dark_level_reg <= rbd_pkg::DARK_LEVEL_RST;
      end else if (apb_wr) begin
         case (paddr)
            rbd_pkg::CTRL_OFS: begin
               static_en_reg <= pwdata[rbd_pkg::STATIC_EN_BIT];
               dynamic_en_reg <= pwdata[rbd_pkg::DYNAMIC_EN_BIT];
               cluster_bound_reg <= pwdata[rbd_pkg::CLUSTER_LSB +: 2];
               manual_op_reg <= pwdata[rbd_pkg::MANUAL_OP_BIT];
            end
            rbd_pkg::BLACK_LEVEL_OFS: black_level_reg <= pwdata[15:0];
            rbd_pkg::ANALOG_GAIN_OFS: analog_gain_reg <= pwdata[15:0];
            rbd_pkg::SENSOR_DGAIN_OFS: sensor_gain_reg <= pwdata[15:0];
            rbd_pkg::PIPE_DGAIN_OFS: pipe_gain_reg <= pwdata[15:0];
            rbd_pkg::DYN_THRESH_OFS: dyn_thresh_reg <= pwdata[15:0];
            rbd_pkg::DARK_LEVEL_OFS: dark_level_reg <= pwdata[15:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Stage 0: black level subtraction and pipeline digital gain
   // ----------------------------------------------------------------------
   logic [16:0] blc_diff;
   logic [PIX_W-1:0] blc_pix;
   logic [PROD_W-1:0] gain_prod;
   logic [PROD_W-1:0] gain_shift;
   logic [PIX_W-1:0] gain_pix;
   logic s0_valid_reg;
   logic [E_W-1:0] s0_elem_reg;
   logic [rbd_pkg::POS_W-1:0] col_reg;
   logic [rbd_pkg::POS_W-1:0] row_reg;
   logic [rbd_pkg::POS_W-1:0] s0_col_reg;
   logic [rbd_pkg::POS_W-1:0] s0_row_reg;

   // Offset removed first so later stages see data linear from zero
   assign blc_diff = 17'(in_pixel) - {1'b0, black_level_reg};  // RULE_01
   assign blc_pix = blc_diff[16] ? '0 : PIX_W'(blc_diff);  // RULE_01
   assign gain_prod = PROD_W'(blc_pix) * PROD_W'(pipe_gain_reg);  // RULE_02
   assign gain_shift = gain_prod >> rbd_pkg::GAIN_FRAC;  // RULE_02
   assign gain_pix = (gain_shift > PROD_W'(PIX_MAX)) ? PIX_MAX : PIX_W'(gain_shift);

   // Position of the entering pixel; a frame start forces row and column to zero
   always_ff @(posedge clk) begin
      if (reset) begin
         s0_valid_reg <= 1'b0;
         s0_elem_reg <= '0;
         col_reg <= '0;
         row_reg <= '0;
         s0_col_reg <= '0;
         s0_row_reg <= '0;
      end else begin
         s0_valid_reg <= in_valid;
         if (in_valid) begin
            s0_elem_reg <= {in_sof, in_eol, gain_pix};
            s0_col_reg <= in_sof ? '0 : col_reg;
            s0_row_reg <= in_sof ? '0 : row_reg;
            col_reg <= in_eol ? '0 : (in_sof ? 16'h0001 : col_reg + 1'b1);
            row_reg <= (in_sof ? '0 : row_reg) + (in_eol ? 16'h0001 : 16'h0000);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Line buffers and 5x5 window; markers travel with the pixels
   // ----------------------------------------------------------------------
   logic [E_W-1:0] row_tap [0:4];
   logic [E_W-1:0] win [0:4][0:4];
   logic w_valid_reg;
   logic interior_reg;

   assign row_tap[0] = s0_elem_reg;

   // Four lines of storage give the five window rows
   for (genvar r = 1; r < rbd_pkg::WIN; r++) begin : g_lines
      rbd_line_buf #(
         .WIDTH(E_W),
         .DEPTH(LINE_W)
      ) u_line (
         .clk(clk),
         .reset(reset),
         .en(s0_valid_reg),
         .din(row_tap[r-1]),
         .dout(row_tap[r])
      );  // RULE_15
   end

   // Window shifts only on accepted pixels, so gaps in the stream are kept
   always_ff @(posedge clk) begin
      if (reset) begin
         w_valid_reg <= 1'b0;
         interior_reg <= 1'b0;
         for (int r = 0; r < rbd_pkg::WIN; r++) begin
            for (int c = 0; c < rbd_pkg::WIN; c++) begin
               win[r][c] <= '0;
            end
         end
      end else begin
         w_valid_reg <= s0_valid_reg;  // RULE_15
         if (s0_valid_reg) begin
            interior_reg <= (s0_col_reg >= rbd_pkg::BORDER) && (s0_row_reg >= rbd_pkg::BORDER);
            for (int r = 0; r < rbd_pkg::WIN; r++) begin
               win[r][0] <= row_tap[r];
               for (int c = 1; c < rbd_pkg::WIN; c++) begin
                  win[r][c] <= win[r][c-1];
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Defect decision on the raw centre pixel
   // ----------------------------------------------------------------------
   logic [PIX_W-1:0] centre;
   logic [PIX_W-1:0] nbr [0:7];
   logic [PIX_W-1:0] hi_good;
   logic [PIX_W-1:0] lo_good;
   logic [PIX_W-1:0] med_a;
   logic [PIX_W-1:0] med_b;
   logic [PIX_W:0] med_sum;
   logic [PIX_W-1:0] estimate;
   logic bright_hit;
   logic dark_hit;
   logic fix_now;

   // Offsets of two rows or columns keep every neighbour in the centre's colour
   assign centre = win[2][2][PIX_W-1:0];  // RULE_04
   assign nbr[0] = win[0][0][PIX_W-1:0];  // RULE_08
   assign nbr[1] = win[0][2][PIX_W-1:0];
   assign nbr[2] = win[0][4][PIX_W-1:0];
   assign nbr[3] = win[2][0][PIX_W-1:0];
   assign nbr[4] = win[2][4][PIX_W-1:0];
   assign nbr[5] = win[4][0][PIX_W-1:0];
   assign nbr[6] = win[4][2][PIX_W-1:0];
   assign nbr[7] = win[4][4][PIX_W-1:0];

   // Skipping as many extremes as the cluster bound lets clustered defects hide
   // no good reference; beyond three the estimate is no longer trusted
   assign hi_good = rank_pick(nbr, {1'b0, cluster_bound_reg});  // RULE_06
   assign lo_good = rank_pick(nbr, 3'(7 - 32'(cluster_bound_reg)));  // RULE_07
   assign med_a = rank_pick(nbr, 3'h3);  // RULE_14
   assign med_b = rank_pick(nbr, 3'h4);
   assign med_sum = {1'b0, med_a} + {1'b0, med_b};
   assign estimate = med_sum[PIX_W:1];  // RULE_14

   // Bright test against the brightest trusted neighbour
   assign bright_hit = dynamic_en_reg &&
                       ({1'b0, centre} > wide_add(hi_good, dyn_thresh_reg));  // RULE_10
   // Dark test: pixel pinned near zero while trusted neighbours are lit
   assign dark_hit = static_en_reg && (16'(centre) <= dark_level_reg) &&
                     (wide_add(centre, dyn_thresh_reg) < {1'b0, lo_good});  // RULE_09
   // Static bright point: far above even the brightest trusted neighbour
   assign fix_now = interior_reg && (bright_hit || dark_hit ||
                    (static_en_reg && ({1'b0, centre} >
                     wide_add(hi_good, dyn_thresh_reg << 1))));  // RULE_05

   // ----------------------------------------------------------------------
   // Output stage and corrected pixel count per frame
   // ----------------------------------------------------------------------
   assign fix_count_next = win[2][2][PIX_W+1] ? 16'(fix_now) :
                           ((fix_now && fix_count_reg != 16'hFFFF) ?
                            fix_count_reg + 1'b1 : fix_count_reg);

   // Replacement or pass-through; frame markers of the centre go out with it
   always_ff @(posedge clk) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_pixel <= '0;
         out_sof <= 1'b0;
         out_eol <= 1'b0;
         fix_count_reg <= '0;
      end else begin
         out_valid <= w_valid_reg;  // RULE_15
         if (w_valid_reg) begin
            out_pixel <= fix_now ? estimate : centre;  // RULE_14
            out_sof <= win[2][2][PIX_W+1];
            out_eol <= win[2][2][PIX_W];
            fix_count_reg <= fix_count_next;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_blc_floor;
      @(posedge clk) disable iff (reset)
      (in_valid && (16'(in_pixel) <= black_level_reg)) |=> (s0_elem_reg[PIX_W-1:0] == '0);
   endproperty
   a_blc_floor: assert property (p_blc_floor) else $error("black level not clamped to zero");  // RULE_01

   property p_unity_gain;
      @(posedge clk) disable iff (reset)
      (in_valid && pipe_gain_reg == rbd_pkg::GAIN_UNITY && 16'(in_pixel) > black_level_reg)
      |=> (s0_elem_reg[PIX_W-1:0] == PIX_W'($past(in_pixel) - $past(black_level_reg)));
   endproperty
   a_unity_gain: assert property (p_unity_gain) else $error("unity gain altered the pixel");  // RULE_02

   property p_latency;
      @(posedge clk) disable iff (reset)
      in_valid |-> ##3 out_valid;
   endproperty
   a_latency: assert property (p_latency) else $error("output not three cycles after input");  // RULE_15

   property p_no_extra;
      @(posedge clk) disable iff (reset)
      !in_valid |-> ##3 !out_valid;
   endproperty
   a_no_extra: assert property (p_no_extra) else $error("output without matching input");  // RULE_15

   property p_pass;
      @(posedge clk) disable iff (reset)
      (w_valid_reg && !fix_now) |=> (out_pixel == $past(centre));
   endproperty
   a_pass: assert property (p_pass) else $error("good pixel was changed");  // RULE_14

   property p_bright;
      @(posedge clk) disable iff (reset)
      (w_valid_reg && interior_reg && dynamic_en_reg &&
       ({1'b0, centre} > wide_add(hi_good, dyn_thresh_reg))) |=> (out_pixel == $past(estimate));
   endproperty
   a_bright: assert property (p_bright) else $error("bright defect not replaced");  // RULE_10

   property p_disabled;
      @(posedge clk) disable iff (reset)
      (w_valid_reg && !static_en_reg && !dynamic_en_reg) |=> (out_pixel == $past(centre));
   endproperty
   a_disabled: assert property (p_disabled) else $error("correction active while disabled");  // RULE_11

   property p_border;
      @(posedge clk) disable iff (reset)
      (w_valid_reg && !interior_reg) |=> (out_pixel == $past(centre));
   endproperty
   a_border: assert property (p_border) else $error("border pixel was changed");  // RULE_04

   property p_reset_vals;
      @(posedge clk)
      $past(reset) |-> (!static_en_reg && !dynamic_en_reg && cluster_bound_reg == 2'h2);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("control reset values wrong");  // RULE_13

endmodule : rbd_top

`default_nettype wire

// File: verification/raw_black_level_defect_fix_tb.sv
// Self-checking bench: registers over APB, black level, gain and defect fixing
`timescale 1ns/100ps
`default_nettype none

module raw_black_level_defect_fix_tb;
   localparam int LW = 8;
   localparam int NPIX = LW*11;
   localparam int LAG = 2*LW+2;
   logic clk, reset, psel, penable, pwrite, pready, pslverr;
   logic in_valid, in_sof, in_eol, out_valid, out_sof, out_eol;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [11:0] in_pixel, out_pixel;
   logic [11:0] exp_img [64];
   logic [11:0] outs [$];
   logic [2:0] vh;
   logic [15:0] bl, gain;
   int miscompares, tests_run, n_base;

   rbd_top #(.PIX_W(12), .LINE_W(LW)) i_dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_pixel(in_pixel),
      .in_sof(in_sof), .in_eol(in_eol), .out_valid(out_valid), .out_pixel(out_pixel),
      .out_sof(out_sof), .out_eol(out_eol));
   rbd_sensor_model #(.PIX_W(12), .LINE_W(LW), .ROWS(11)) i_sensor (.clk(clk),
      .in_valid(in_valid), .in_pixel(in_pixel), .in_sof(in_sof), .in_eol(in_eol));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Output capture; the valid delay is watched on every active cycle
   always @(posedge clk) begin
      if (out_valid === 1'b1) outs.push_back(out_pixel);
      if (!reset && (vh[2] || out_valid === 1'b1)) check(out_valid, vh[2]);
      vh <= {vh[1:0], in_valid};
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One APB transfer; waits on pready, bounded so a hang shows as a mismatch
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) miscompares++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic e);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      check(rd, d);
      check(err, e);
   endtask : rd_chk

   // Reference pixel: clamp after black level, gain with 1024 as unity, saturate
   function automatic logic [11:0] proc(input logic [11:0] v);
      logic [31:0] t;
      t = (v > bl) ? (((32'(v) - 32'(bl)) * 32'(gain)) >> 10) : 32'h0000_0000;
      return (t > 32'h0000_0fff) ? 12'hfff : t[11:0];
   endfunction : proc

   task automatic fill(input logic [11:0] v);
      for (int i = 0; i < NPIX; i++) i_sensor.img[i] = v;
      for (int i = 0; i < 64; i++) exp_img[i] = proc(v);
   endtask : fill

   task automatic poke(input int i, input logic [11:0] v, input logic [11:0] e);
      i_sensor.img[i] = v;
      if (i < 64) exp_img[i] = e;
   endtask : poke

   // Rows 8..10 only flush the window, so the first 64 pixels are judged
   task automatic frame(input int gap);
      int k;
      i_sensor.send_frame(gap);
      repeat (8) @(posedge clk);
      for (int i = 0; i < 64; i++) begin
         k = n_base + LAG + i;
         if (k < outs.size()) check(outs[k], exp_img[i]);
         else miscompares++;
      end
      n_base += NPIX;
   endtask : frame

   task automatic t_regs();
      rd_chk(rbd_pkg::CTRL_OFS, 32'h0000_0020, 1'b0);
      rd_chk(rbd_pkg::ANALOG_GAIN_OFS, 32'h0000_0400, 1'b0);
      rd_chk(rbd_pkg::SENSOR_DGAIN_OFS, 32'h0000_0400, 1'b0);
      rd_chk(rbd_pkg::PIPE_DGAIN_OFS, 32'h0000_0400, 1'b0);
      rd_chk(8'h20, 32'h0000_0000, 1'b1);
      wr(rbd_pkg::CTRL_OFS, 32'h0000_0033);
      rd_chk(rbd_pkg::CTRL_OFS, 32'h0000_0033, 1'b0);
      $display("Test registers done");
   endtask : t_regs

   // Offset 0x40, gain 2x, correction off: clamp at zero and saturation
   task automatic t_black();
      bl = 16'h0040;
      gain = 16'h0800;
      wr(rbd_pkg::BLACK_LEVEL_OFS, 32'h0000_0040);
      wr(rbd_pkg::PIPE_DGAIN_OFS, 32'h0000_0800);
      wr(rbd_pkg::CTRL_OFS, 32'h0000_0020);
      fill(12'h240);
      poke(0, 12'h020, 12'h000);
      poke(63, 12'hfff, 12'hfff);
      frame(0);
      bl = 16'h0000;
      gain = 16'h0400;
      wr(rbd_pkg::BLACK_LEVEL_OFS, 32'h0000_0000);
      wr(rbd_pkg::PIPE_DGAIN_OFS, 32'h0000_0400);
      $display("Test black level done");
   endtask : t_black

   // Hot pixels in two channels: untouched while off, each fixed when on
   task automatic t_dyn();
      fill(12'h100);
      poke(36, 12'hfff, 12'hfff);
      poke(37, 12'hfff, 12'hfff);
      frame(0);
      wr(rbd_pkg::CTRL_OFS, 32'h0000_0022);
      poke(36, 12'hfff, 12'h100);
      poke(37, 12'hfff, 12'h100);
      frame(0);
      $display("Test dynamic defect done");
   endtask : t_dyn

   task automatic t_dark();
      wr(rbd_pkg::CTRL_OFS, 32'h0000_0021);
      fill(12'h300);
      poke(45, 12'h000, 12'h300);
      frame(0);
      $display("Test dark defect done");
   endtask : t_dark

   // Three same-colour defects in one column, bound 3, slow sensor
   task automatic t_cluster();
      wr(rbd_pkg::CTRL_OFS, 32'h0000_0032);
      fill(12'h100);
      poke(36, 12'hfff, 12'h100);
      poke(52, 12'hfff, 12'h100);
      poke(68, 12'hfff, 12'h100);
      frame(2);
      $display("Test cluster done");
   endtask : t_cluster

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   // Main sequence after five reset cycles
   initial begin
      {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {miscompares, tests_run, n_base, vh, bl, gain} = {96'h0, 3'h0, 16'h0, 16'h0400};
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_black();
      t_dyn();
      t_dark();
      t_cluster();
      close_out();
   end

   // Watchdog far beyond the roughly 710 cycles the tests take
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      close_out();
   end
endmodule : raw_black_level_defect_fix_tb
`default_nettype wire

// File: verification/rbd_sensor_model.sv
// Raw sensor stand-in that streams one stored frame line by line
`timescale 1ns/100ps
`default_nettype none

module rbd_sensor_model #(
   parameter int PIX_W = 12,
   parameter int LINE_W = 8,
   parameter int ROWS = 11
) (
   input wire logic clk,
   output logic in_valid,
   output logic [PIX_W-1:0] in_pixel,
   output logic in_sof,
   output logic in_eol
);
   logic [PIX_W-1:0] img [LINE_W*ROWS];

   // Quiet stream at time zero
   initial begin
      in_valid = 1'b0;
      in_pixel = '0;
      in_sof = 1'b0;
      in_eol = 1'b0;
   end

   // Idle cycle: the data line toggles so a stale pixel never looks valid
   task automatic idle();
      @(posedge clk);
      in_valid <= 1'b0;
      in_sof <= 1'b0;
      in_eol <= 1'b0;
      in_pixel <= ~in_pixel;
   endtask : idle

   // One frame; gap idle cycles after each pixel model a slow sensor
   task automatic send_frame(input int gap);
      for (int i = 0; i < LINE_W*ROWS; i++) begin
         @(posedge clk);
         in_valid <= 1'b1;
         in_pixel <= img[i];
         in_sof <= (i == 0);
         in_eol <= (i % LINE_W == LINE_W-1);
         repeat (gap) idle();
      end
      idle();
   endtask : send_frame
endmodule : rbd_sensor_model
`default_nettype wire
